/* design/adc_sequencer_serial_port.sv */
`timescale 1ns/100ps
`include "adc_seq_regs.svh"
module adc_sequencer_serial_port
    import adc_seq_pkg::*;
#(
    parameter int CLK_HZ    = `CLK_HZ,
    parameter int MASTER_HZ = `MASTER_HZ,
    parameter int MOD_HZ    = `MOD_HZ
)(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       serial_select_n_i,
    input  wire logic       sclk_i,
    input  wire logic       serial_in_i,
    output logic            serial_out_o,
    output logic            serial_out_oe_o,
    output logic            ready_n_o,
    input  wire logic       modulator_bit_i,
    output logic            modulator_strobe_o,
    output logic            converter_active_o,
    output logic [4:0]      input_select_o,
    output logic [2:0]      meas_mode_o,
    output logic [2:0]      data_rate_o
);
    localparam int MASTER_DIV  = CLK_HZ / MASTER_HZ;
    localparam int MOD_DIV     = MASTER_HZ / MOD_HZ;
    localparam int READY_CYC_I =
        int'((64'(`READY_PULSE_NS) * CLK_HZ) / 64'd1000000000);
    localparam logic [11:0] READY_CYC = 12'(READY_CYC_I);

    if (MASTER_DIV < 2 || MOD_DIV < 1 || MASTER_DIV > 255 || MOD_DIV > 15
        || READY_CYC_I < 1 || READY_CYC_I > 4095) begin : g_bad_clk
        $error("Clock ratios out of range");
    end

    serial_frame_if frm ();

    serial_frame_shifter u_shifter (
        .clk_i             (clk_i),
        .resetn_i          (resetn_i),
        .serial_select_n_i (serial_select_n_i),
        .sclk_i            (sclk_i),
        .serial_in_i       (serial_in_i),
        .serial_out_o      (serial_out_o),
        .serial_out_oe_o   (serial_out_oe_o),
        .frm               (frm.shifter)
    );

    // Register file
    logic [31:0][15:0] regs;
    logic              write_hit_ctrl;
    logic              busy;
    seq_state_e        state;

    function automatic word_t reg_default(input logic [4:0] a);
        case (a)
            `REG_CTRL1: reg_default = `DEF_CTRL1;
            `REG_MISC1: reg_default = `DEF_MISC1;
            `REG_MISC2: reg_default = `DEF_MISC2;
            default:    reg_default = `DEF_OTHER;
        endcase
    endfunction

    // Reads commit shifted-in data too, so one commit path serves both
    for (genvar i = 1; i < 32; i++) begin : g_reg
        logic [15:0] q;
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                q <= reg_default(5'(i));
            end else if (frm.commit_stb && frm.addr == 5'(i)) begin
                q <= frm.wdata;
            end
        end
        assign regs[i] = q;
    end

    assign write_hit_ctrl = frm.commit_stb && frm.addr == `REG_CTRL1;

    // Control bit 15 reads back conversion status
    always_comb begin
        if (frm.addr == `REG_CTRL1) begin
            frm.rdata = {~busy, regs[`REG_CTRL1][14:0]};
        end else begin
            frm.rdata = regs[frm.addr];
        end
    end

    logic       pd;
    logic [2:0] rate;
    assign pd   = regs[`REG_CTRL1][`PD_BIT];
    assign rate = regs[`REG_CTRL1][`RATE_MSB:`RATE_LSB];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            input_select_o <= 5'h00;
            meas_mode_o    <= 3'h0;
            data_rate_o    <= 3'h4;
        end else begin
            input_select_o <=
                regs[`REG_CTRL2][`PSEL_MSB:`PSEL_LSB];
            meas_mode_o    <=
                regs[`REG_CTRL1][`MEAS_MSB:`MEAS_LSB];
            data_rate_o    <= rate;
        end
    end

    // Single-shot request: mode bit written 0 then 1 while powered down
    logic mode_written;
    logic start_single;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode_written <= 1'b0;
        end else if (write_hit_ctrl) begin
            mode_written <= frm.wdata[`CONV_MODE_BIT];
        end
    end
    assign start_single = write_hit_ctrl && frm.wdata[`CONV_MODE_BIT]
                          && frm.wdata[`PD_BIT] && !mode_written
                          && state == SEQ_IDLE;

    // Master clock and modulator tick dividers
    logic [7:0] master_cnt;
    logic [3:0] mod_cnt;
    logic       master_tick;
    logic       mod_tick;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            master_cnt <= 8'h00;
            mod_cnt    <= 4'h0;
        end else begin
            master_cnt <= master_tick ? 8'h00 : master_cnt + 8'h01;
            if (master_tick) begin
                mod_cnt <= mod_tick ? 4'h0 : mod_cnt + 4'h1;
            end
        end
    end
    assign master_tick = master_cnt == 8'(MASTER_DIV - 1);
    assign mod_tick    = master_tick
                         && mod_cnt == 4'(MOD_DIV - 1);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) modulator_strobe_o <= 1'b0;
        else           modulator_strobe_o <= mod_tick && busy;
    end

    logic [1:0] mbit_m;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) mbit_m <= 2'h0;
        else           mbit_m <= {mbit_m[0], modulator_bit_i};
    end

    // Oversampling ratio and gain 2^31/ratio per rate code
    function automatic logic [14:0] osr_of(input logic [2:0] r);
        case (r)
            3'h0: osr_of = 15'd31250;
            3'h1: osr_of = 15'd15625;
            3'h2: osr_of = 15'd7812;
            3'h3: osr_of = 15'd3906;
            3'h4: osr_of = 15'd1953;
            3'h5: osr_of = 15'd1000;
            3'h6: osr_of = 15'd526;
            default: osr_of = 15'd290;
        endcase
    endfunction

    function automatic logic [23:0] gain_of(input logic [2:0] r);
        case (r)
            3'h0: gain_of = 24'd68719;
            3'h1: gain_of = 24'd137439;
            3'h2: gain_of = 24'd274896;
            3'h3: gain_of = 24'd549791;
            3'h4: gain_of = 24'd1099582;
            3'h5: gain_of = 24'd2147484;
            3'h6: gain_of = 24'd4082669;
            default: gain_of = 24'd7405116;
        endcase
    endfunction

    // Sinc1 decimator
    logic [2:0]         conv_rate;
    logic [14:0]        sample_cnt;
    logic signed [16:0] acc;
    logic               conv_done;
    logic               single;
    assign busy      = state == SEQ_CONV;
    assign conv_done = busy && mod_tick
                       && sample_cnt == osr_of(conv_rate) - 15'd1;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sample_cnt <= 15'h0000;
            acc        <= 17'sh00000;
            conv_rate  <= 3'h4;
        end else if (!busy || conv_done) begin
            sample_cnt <= 15'h0000;
            acc        <= 17'sh00000;
            conv_rate  <= rate;
        end else if (mod_tick) begin
            sample_cnt <= sample_cnt + 15'd1;
            acc <= mbit_m[1] ? acc + 17'sd1 : acc - 17'sd1;
        end
    end

    // Scale, saturate and clamp the final sum
    logic signed [16:0] acc_last;
    logic signed [41:0] product;
    logic signed [25:0] scaled;
    logic [15:0]        result;
    assign acc_last = mbit_m[1] ? acc + 17'sd1 : acc - 17'sd1;
    assign product  = acc_last * $signed({1'b0, gain_of(conv_rate)});
    assign scaled   = product[41:16];

    always_comb begin
        if (scaled > 26'sd32767) begin
            result = 16'h7FFF;
        end else if (scaled < -26'sd32768) begin
            result = 16'h8000;
        end else begin
            result = scaled[15:0];
        end
        if (meas_mode_o != 3'h0 && result[15]) begin
            result = 16'h0000;
        end
    end

    // Sequencer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state  <= SEQ_IDLE;
            single <= 1'b0;
        end else begin
            unique case (state)
                SEQ_IDLE: begin
                    if (start_single) begin
                        state  <= SEQ_CONV;
                        single <= 1'b1;
                    end else if (!pd) begin
                        state  <= SEQ_CONV;
                        single <= 1'b0;
                    end
                end
                SEQ_CONV: begin
                    if (!single && pd) begin
                        state <= SEQ_IDLE;
                    end else if (conv_done) begin
                        state <= SEQ_DONE;
                    end
                end
                SEQ_DONE: begin
                    if (single || pd) begin
                        state  <= SEQ_IDLE;
                        single <= 1'b0;
                    end else begin
                        state <= SEQ_CONV;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) converter_active_o <= 1'b0;
        else           converter_active_o <= state != SEQ_IDLE;
    end

    // Result register with deferred update
    logic [15:0] pend_val;
    logic        pend;
    logic [15:0] result_reg;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend     <= 1'b0;
            pend_val <= 16'h0000;
        end else if (conv_done) begin
            pend     <= 1'b1; // Set wins over the clear below
            pend_val <= result;
        end else if (pend && frm.idle) begin
            pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            result_reg <= `DEF_OTHER;
        end else if (pend && frm.idle && !conv_done) begin
            result_reg <= pend_val;
        end
    end
    assign regs[0] = result_reg;

    // Ready indication: short pulse when continuous, held when single
    logic [11:0] ready_cnt;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ready_cnt <= 12'h000;
            ready_n_o <= 1'b1;
        end else if (conv_done && single) begin
            ready_n_o <= 1'b0;
            ready_cnt <= 12'h000;
        end else if (conv_done) begin
            ready_n_o <= 1'b0;
            ready_cnt <= READY_CYC;
        end else if (state == SEQ_IDLE && (start_single || !pd)) begin
            // A start from SEQ_IDLE cuts any pulse still running
            ready_n_o <= 1'b1;
            ready_cnt <= 12'h000;
        end else if (ready_cnt > 12'h001) begin
            ready_cnt <= ready_cnt - 12'h001;
        end else if (ready_cnt == 12'h001) begin
            ready_cnt <= 12'h000;
            ready_n_o <= 1'b1;
        end
    end
endmodule

/* common/adc_seq_regs.svh */
`ifndef ADC_SEQ_REGS_SVH
`define ADC_SEQ_REGS_SVH

`define FRAME_BITS      5'd24
`define HDR_BITS        5'd8
`define RW_BIT          21
`define ADDR_MSB        20
`define ADDR_LSB        16

`define REG_RESULT      5'h00
`define REG_CTRL1       5'h01
`define REG_MISC1       5'h02
`define REG_MISC2       5'h03
`define REG_CTRL2       5'h10

`define DEF_CTRL1       16'h01C3
`define DEF_MISC1       16'h8000
`define DEF_MISC2       16'h7FFF
`define DEF_OTHER       16'h0000

`define CONV_MODE_BIT   15
`define PD_BIT          7
`define RATE_MSB        6
`define RATE_LSB        4
`define MEAS_MSB        13
`define MEAS_LSB        11
`define PSEL_MSB        4
`define PSEL_LSB        0

`define CLK_HZ          100000000
`define MASTER_HZ       1000000
`define MOD_HZ          250000
`define READY_PULSE_NS  8000

`endif

/* common/adc_seq_pkg.sv */
package adc_seq_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_CONV = 2'b01,
        SEQ_DONE = 2'b11
    } seq_state_e;
endpackage

/* common/serial_frame_if.sv */
`timescale 1ns/100ps
interface serial_frame_if;
    logic [4:0]  addr;
    logic        rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        hdr_stb;
    logic        commit_stb;
    logic        idle;
    modport shifter (output addr, rd, wdata, hdr_stb, commit_stb, idle,
                     input rdata);
    modport core    (input addr, rd, wdata, hdr_stb, commit_stb, idle,
                     output rdata);
endinterface

/* design/serial_frame_shifter.sv */
`timescale 1ns/100ps
`include "adc_seq_regs.svh"
module serial_frame_shifter
    import adc_seq_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic serial_select_n_i,
    input  wire logic sclk_i,
    input  wire logic serial_in_i,
    output logic      serial_out_o,
    output logic      serial_out_oe_o,
    serial_frame_if.shifter frm
);
    logic [1:0]  sel_m, sclk_m, din_m;
    logic        sclk_d;
    logic [4:0]  count;
    logic [22:0] shift_in;
    logic [15:0] out_sh;
    logic        sel_s, sclk_s, din_s, rise, fall;

    // Two-stage synchronisers; stage 0 feeds only stage 1
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_m  <= 2'h3;
            sclk_m <= 2'h0;
            din_m  <= 2'h0;
        end else begin
            sel_m  <= {sel_m[0], serial_select_n_i};
            sclk_m <= {sclk_m[0], sclk_i};
            din_m  <= {din_m[0], serial_in_i};
        end
    end
    assign sel_s  = sel_m[1];
    assign sclk_s = sclk_m[1];
    assign din_s  = din_m[1];

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) sclk_d <= 1'b0;
        else           sclk_d <= sclk_s;
    end
    assign rise = sclk_s & ~sclk_d & ~sel_s;
    assign fall = ~sclk_s & sclk_d & ~sel_s;

    // Input side: MSB first, sampled on falling edges
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count          <= 5'h00;
            shift_in       <= 23'h000000;
            frm.hdr_stb    <= 1'b0;
            frm.commit_stb <= 1'b0;
            frm.addr       <= 5'h00;
            frm.rd         <= 1'b0;
            frm.wdata      <= 16'h0000;
        end else begin
            frm.hdr_stb    <= 1'b0;
            frm.commit_stb <= 1'b0;
            if (sel_s) begin
                count <= 5'h00;
            end else if (fall) begin
                shift_in <= {shift_in[21:0], din_s};
                if (count == `HDR_BITS - 5'd1) begin
                    // Bit 16 is arriving now; bits 23..17 sit in [6:0]
                    frm.addr    <= {shift_in[3:0], din_s};
                    frm.rd      <= shift_in[4];
                    frm.hdr_stb <= 1'b1;
                end
                if (count == `FRAME_BITS - 5'd1) begin
                    count          <= 5'h00;
                    frm.wdata      <= {shift_in[14:0], din_s};
                    frm.commit_stb <= 1'b1;
                end else begin
                    count <= count + 5'd1;
                end
            end
        end
    end
    assign frm.idle = (count == 5'h00);

    // Output side: loaded at header, advanced on rising edges
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_sh       <= 16'h0000;
            serial_out_o <= 1'b0;
        end else if (sel_s) begin
            serial_out_o <= 1'b0;
        end else if (frm.hdr_stb) begin
            out_sh <= frm.rdata;
        end else if (rise && frm.rd && count >= `HDR_BITS) begin
            serial_out_o <= out_sh[15];
            out_sh       <= {out_sh[14:0], 1'b0};
        end
    end
    assign serial_out_oe_o = ~sel_s & frm.rd & (count >= `HDR_BITS);
endmodule

/* verification/adc_seq_monitor.sv */
`timescale 1ns/100ps
module adc_seq_monitor (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       serial_select_n_i,
    input  wire logic       sclk_i,
    input  wire logic       serial_out_o,
    input  wire logic       serial_out_oe_o,
    input  wire logic       ready_n_o,
    input  wire logic       modulator_strobe_o,
    input  wire logic       converter_active_o,
    input  wire logic [2:0] data_rate_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    AST_RESET_STATE: assert property (
        $rose(resetn_i) |-> ready_n_o && !converter_active_o
            && !serial_out_oe_o && data_rate_o == 3'h4)
        else $error("Outputs not at reset values");
    AST_SELECT_IDLE: assert property (
        serial_select_n_i [*4] |-> !serial_out_oe_o && !serial_out_o)
        else $error("Serial output driven while deselected");
    AST_STROBE_ACTIVE: assert property (
        modulator_strobe_o |-> converter_active_o
            || $past(converter_active_o))
        else $error("Modulator tick while powered down");
    AST_STROBE_SPACING: assert property (
        modulator_strobe_o |=> !modulator_strobe_o [*3])
        else $error("Modulator ticks too close");
    AST_READY_AFTER_CONV: assert property (
        $fell(ready_n_o) |-> converter_active_o
            || $past(converter_active_o) || $past(converter_active_o, 2))
        else $error("Ready without a conversion");
    AST_READY_HOLD: assert property (
        $fell(ready_n_o) |=> !ready_n_o [*8])
        else $error("Ready pulse too short");
    AST_READY_CLEARED_ON_START: assert property (
        $rose(converter_active_o) |-> ##[0:2] ready_n_o)
        else $error("Ready still low at conversion start");
    AST_OUT_ON_RISE: assert property (
        serial_out_oe_o && $past(serial_out_oe_o) && $changed(serial_out_o)
            |-> $past(sclk_i, 2))
        else $error("Serial output moved away from a rising edge");
endmodule

bind adc_sequencer_serial_port adc_seq_monitor u_mon (
    .clk_i              (clk_i),
    .resetn_i           (resetn_i),
    .serial_select_n_i  (serial_select_n_i),
    .sclk_i             (sclk_i),
    .serial_out_o       (serial_out_o),
    .serial_out_oe_o    (serial_out_oe_o),
    .ready_n_o          (ready_n_o),
    .modulator_strobe_o (modulator_strobe_o),
    .converter_active_o (converter_active_o),
    .data_rate_o        (data_rate_o)
);

/* verification/serial_host_model.sv */
`timescale 1ns/100ps
module serial_host_model (
    input  wire logic clk_i,
    input  wire logic serial_out_i,
    output logic      serial_select_n_o,
    output logic      sclk_o,
    output logic      serial_in_o
);
    initial begin
        serial_select_n_o = 1'b1;
        sclk_o            = 1'b0;
        serial_in_o       = 1'b0;
    end

    // One 24-bit frame, five clocks per serial clock phase
    task automatic xfer(input logic [23:0] f, input bit hold,
                        output logic [15:0] rd);
        int i;
        @(posedge clk_i);
        #1 serial_select_n_o = 1'b0;
        repeat (5) @(posedge clk_i);
        for (i = 23; i >= 0; i--) begin
            #1 sclk_o = 1'b1;
            serial_in_o = f[i];
            repeat (5) @(posedge clk_i);
            if (i < 16)
                rd[i] = serial_out_i;
            #1 sclk_o = 1'b0;
            repeat (5) @(posedge clk_i);
        end
        // Released line shows the inverse, not a stale copy
        #1 serial_in_o = ~serial_in_o;
        if (!hold)
            serial_select_n_o = 1'b1;
        repeat (5) @(posedge clk_i);
    endtask
endmodule

/* verification/adc_sequencer_serial_port_bench.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("Error %0t: got %h expected %h", $time, a, b); end end
module adc_sequencer_serial_port_bench;
    import adc_seq_pkg::*;
    logic       clk_i = 1'b0;
    logic       resetn_i = 1'b0;
    logic       modulator_bit_i = 1'b0;
    logic       sel_n, sclk, serial_in, serial_out, oe, ready_n, strobe, active;
    logic [4:0] in_sel;
    logic [2:0] meas, rate;
    int         fail_count = 0;
    int         tests_run = 0;
    int         seed = 41193;
    int         k;
    logic [4:0] a;
    word_t      d1, d2, rd;
    logic [4:0] addrs [4] = '{5'h01, 5'h02, 5'h03, 5'h10};
    word_t      defs [4] = '{16'h01C3, 16'h8000, 16'h7FFF, 16'h0000};

    always #5 clk_i = ~clk_i;

    adc_sequencer_serial_port #(.CLK_HZ(100000000), .MASTER_HZ(25000000),
                                .MOD_HZ(6250000)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .serial_select_n_i(sel_n),
        .sclk_i(sclk), .serial_in_i(serial_in), .serial_out_o(serial_out),
        .serial_out_oe_o(oe), .ready_n_o(ready_n),
        .modulator_bit_i(modulator_bit_i), .modulator_strobe_o(strobe),
        .converter_active_o(active), .input_select_o(in_sel),
        .meas_mode_o(meas), .data_rate_o(rate));

    serial_host_model u_host (.clk_i(clk_i), .serial_out_i(serial_out),
        .serial_select_n_o(sel_n), .sclk_o(sclk), .serial_in_o(serial_in));

    function automatic word_t ctrl(bit m, bit pd, logic [2:0] ms,
                                   logic [2:0] r);
        return {m, 1'b1, ms, 3'b001, pd, r, 4'h0};
    endfunction

    function automatic word_t exp_res(bit b, logic [2:0] ms);
        if (b)
            return 16'h7FFF;
        return (ms != 3'h0) ? 16'h0000 : 16'h8000;
    endfunction

    task automatic wr(logic [4:0] ad, word_t d, bit hold);
        u_host.xfer({2'($random(seed)), 1'b0, ad, d}, hold, rd);
    endtask

    task automatic rdc(logic [4:0] ad, word_t d, word_t e);
        u_host.xfer({2'($random(seed)), 1'b1, ad, d}, 1'b0, rd);
        `CHK(rd, e)
    endtask

    task automatic wait_ready();
        int n;
        for (n = 0; n < 8000 && ready_n !== 1'b0; n++)
            @(posedge clk_i);
        `CHK(ready_n, 1'b0)
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK(rate, 3'h4)
        `CHK(active, 1'b0)
        `CHK(ready_n, 1'b1)
        for (k = 0; k < 4; k++)
            rdc(addrs[k], defs[k], defs[k] | (k == 0 ? 16'h8000 : 16'h0));
        for (k = 0; k < 6; k++) begin
            a = 5'h04 + 5'(($random(seed) & 32'h7FFFFFFF) % 12);
            d1 = 16'($random(seed));
            d2 = 16'($random(seed));
            wr(a, d1, k[0]);
            rdc(a, d2, d1);
            rdc(a, d1, d2);
        end
        d1 = 16'($random(seed));
        wr(5'h10, d1, 1'b0);
        repeat (10) @(posedge clk_i);
        `CHK(in_sel, d1[4:0])
        #1 modulator_bit_i = 1'b1;
        wr(5'h01, ctrl(0, 0, 3'h0, 3'h7), 1'b0);
        repeat (20) @(posedge clk_i);
        `CHK(active, 1'b1)
        `CHK(rate, 3'h7)
        wait_ready();
        rdc(5'h00, 16'h0000, 16'h7FFF);
        wait (ready_n === 1'b1);
        wait_ready();
        wr(5'h01, ctrl(0, 1, 3'h0, 3'h7), 1'b0);
        repeat (10) @(posedge clk_i);
        `CHK(active, 1'b0)
        #1 modulator_bit_i = 1'b0;
        for (k = 0; k < 2; k++) begin
            d1 = ctrl(0, 1, 3'(k), 3'h7);
            wr(5'h01, d1, 1'b0);
            wr(5'h01, ctrl(1, 1, 3'(k), 3'h7), 1'b0);
            rdc(5'h01, d1, d1);
            `CHK(meas, 3'(k))
            wait_ready();
            repeat (5) @(posedge clk_i);
            `CHK(active, 1'b0)
            rdc(5'h00, 16'h0000, exp_res(1'b0, 3'(k)));
        end
        report_and_stop();
    end
endmodule
